/* File: rmi_map.vh */
// rmi_map.vh: constants of the remote message interface
`ifndef RMI_MAP_VH
`define RMI_MAP_VH
// register byte offsets
`define RMI_OFS_CTRL 4'h0
`define RMI_OFS_ADDR 4'h4
`define RMI_OFS_STAT 4'h8
// control register fields
`define RMI_CTL_IF 0
`define RMI_CTL_PAR 2:1
`define RMI_CTL_LANG 3
`define RMI_CTL_REM 4
`define RMI_CTL_CLR 5
// characters
`define RMI_CH_LF 8'h0A
`define RMI_CH_CR 8'h0D
`define RMI_CH_ETX 8'h03
`define RMI_CH_COMMA 8'h2C
`define RMI_CH_PLUS 8'h2B
`define RMI_CH_MINUS 8'h2D
`define RMI_CH_DOT 8'h2E
`define RMI_CH_EXP 8'h45
`define RMI_CH_DIGIT 4'h3
// reading layout
`define RMI_POS_DIG0 4'h1
`define RMI_POS_DOT 4'h2
`define RMI_POS_FRAC 4'h3
`define RMI_POS_EXP 4'hB
`define RMI_POS_ESGN 4'hC
`define RMI_POS_EHI 4'hD
`define RMI_POS_ELO 4'hE
`define RMI_POS_COMMA 4'hF
// response limit, talk-only address
`define RMI_RESP_MAX 7'h4F
`define RMI_TALK_ONLY 5'h1F
// parity codes and defaults
`define RMI_PAR_NONE 2'h0
`define RMI_PAR_EVEN 2'h1
`define RMI_PAR_ODD 2'h2
`define RMI_PAR_BAD 2'h3
`define RMI_BITS_8 4'h8
`define RMI_BITS_7 4'h7
`define RMI_STOP_BITS 2'h2
`define RMI_ADDR_DEF 5'h16
// formatter states
`define RMI_F_IDLE 3'h0
`define RMI_F_RDG 3'h1
`define RMI_F_NEXT 3'h2
`define RMI_F_RESP 3'h3
`define RMI_F_CR 3'h4
`define RMI_F_LF 3'h5
`endif

/* File: rmi_top.v */
// rmi_top.v: remote message front end with clear, formatter and settings
`include "rmi_map.vh"
module rmi_top (
  // clock, reset, enable
  input wire SYS_CLK,
  input wire RST,
  input wire CE,
  // register port
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  // received bytes from the interface engines
  input wire RX_VALID,
  input wire [7:0] RX_DATA,
  input wire RX_EOI,
  input wire RX_SERIAL,
  input wire GPIB_DCL,
  // message bytes toward the parser
  output reg MSG_VALID,
  output reg [7:0] MSG_DATA,
  output reg PATH_ROOT,
  // clear actions
  output reg MEAS_ABORT,
  output reg TRIG_IDLE,
  output reg BUF_FLUSH,
  output reg DTR,
  // readings in
  input wire RD_VALID,
  input wire RD_NEG,
  input wire [35:0] RD_DIG,
  input wire RD_EXP_NEG,
  input wire [7:0] RD_EXP,
  input wire RD_LAST,
  output reg RD_READY,
  // non-reading responses in
  input wire RESP_VALID,
  input wire [7:0] RESP_DATA,
  input wire RESP_LAST,
  output reg RESP_READY,
  // transmit characters
  output reg TX_VALID,
  output reg [7:0] TX_DATA,
  output reg [10:0] TX_FRAME,
  input wire TX_READY,
  input wire TALK_ADDR,
  // settings out
  output reg IF_GPIB,
  output reg IF_SERIAL,
  output reg TALK_ONLY,
  output reg LANG_ALT,
  output reg [3:0] SER_DATA_BITS,
  output reg SER_PAR_EN,
  output reg SER_PAR_ODD,
  output reg [1:0] SER_STOP_BITS,
  // non-volatile store
  input wire NV_IFSEL,
  input wire [1:0] NV_PARITY,
  input wire NV_LANG,
  output reg NV_STORE
);

  // settings
  reg ifsel;
  reg [1:0] par;
  reg lang;
  reg remote;
  reg [4:0] gaddr;
  reg nv_wait;
  // receive stage
  reg stg_v;
  reg [7:0] stg_d;
  reg stg_e;
  // formatter
  reg [2:0] st;
  reg [3:0] pos;
  reg [6:0] cnt;
  reg l_neg;
  reg [35:0] l_dig;
  reg l_eneg;
  reg [7:0] l_exp;
  reg l_last;

  // combinational values
  reg [2:0] next_st;
  reg [3:0] next_pos;
  reg [6:0] next_cnt;
  reg next_tv;
  reg [7:0] next_td;
  reg next_out_v;
  reg [7:0] next_out_d;
  reg next_end;
  reg next_stg_v;
  reg [7:0] next_stg_d;
  reg next_stg_e;

  wire slot = !TX_VALID | TX_READY;
  wire rd_take = RD_VALID & RD_READY;
  wire resp_take = RESP_VALID & RESP_READY;
  wire rx_ok = RX_VALID & (RX_SERIAL == ifsel);
  wire ctrlc = rx_ok & ifsel & (RX_DATA == `RMI_CH_ETX);
  wire sw_clr = WR & (ADDR == `RMI_OFS_CTRL) & WDATA[`RMI_CTL_CLR];
  wire clr = (GPIB_DCL & !ifsel) | ctrlc | sw_clr;
  wire talk_only = (gaddr == `RMI_TALK_ONLY);
  // serial may send in local when talk-only
  wire allow = ifsel ? (remote | talk_only) : (TALK_ADDR | talk_only);
  wire [2:0] term = ifsel ? `RMI_F_CR : `RMI_F_LF;
  wire ctl_wr = WR & (ADDR == `RMI_OFS_CTRL);

  // ascii digit from a bcd nibble
  function [7:0] asc;
    input [3:0] d;
    begin
      asc = {`RMI_CH_DIGIT, d};
    end
  endfunction

  // one character of a reading at a position
  function [7:0] rdg_char;
    input [3:0] p;
    input neg;
    input [35:0] dig;
    input eneg;
    input [7:0] ex;
    reg [35:0] sh;
    begin
      sh = dig << {p - `RMI_POS_FRAC, 2'b00};
      if (p == 4'h0)
        rdg_char = neg ? `RMI_CH_MINUS : `RMI_CH_PLUS;
      else if (p == `RMI_POS_DIG0)
        rdg_char = asc(dig[35:32]);
      else if (p == `RMI_POS_DOT)
        rdg_char = `RMI_CH_DOT;
      else if (p < `RMI_POS_EXP)
        rdg_char = asc(sh[31:28]);
      else if (p == `RMI_POS_EXP)
        rdg_char = `RMI_CH_EXP;
      else if (p == `RMI_POS_ESGN)
        rdg_char = eneg ? `RMI_CH_MINUS : `RMI_CH_PLUS;
      else if (p == `RMI_POS_EHI)
        rdg_char = asc(ex[7:4]);
      else if (p == `RMI_POS_ELO)
        rdg_char = asc(ex[3:0]);
      else
        rdg_char = `RMI_CH_COMMA;
    end
  endfunction

  // serial frame, lsb first: start, data, parity unless none, two stops
  function [10:0] frame;
    input [7:0] d;
    input [1:0] pm;
    begin
      if (pm == `RMI_PAR_NONE)
        frame = {2'b11, d, 1'b0};
      else
        frame = {2'b11, (pm == `RMI_PAR_ODD) ^ (^d[6:0]), d[6:0], 1'b0};
    end
  endfunction

  // terminator detection with a one-byte stage for carriage return
  always @* begin
    next_out_v = 1'b0;
    next_out_d = stg_d;
    next_end = 1'b0;
    next_stg_v = stg_v;
    next_stg_d = stg_d;
    next_stg_e = stg_e;
    if (stg_v & !(stg_d == `RMI_CH_CR & !stg_e)) begin
      next_out_v = 1'b1;
      next_end = stg_e;
      next_stg_v = 1'b0;
    end
    if (rx_ok & !ctrlc) begin
      if (stg_v & stg_d == `RMI_CH_CR & !stg_e) begin
        if (RX_DATA == `RMI_CH_LF) begin
          next_end = 1'b1;
          next_stg_v = 1'b0;
        end else begin
          next_out_v = 1'b1;
          next_stg_d = RX_DATA;
          next_stg_e = RX_EOI;
        end
      end else if (RX_DATA == `RMI_CH_LF) begin
        next_end = 1'b1;
      end else if (RX_DATA == `RMI_CH_CR & !RX_EOI) begin
        next_stg_v = 1'b1;
        next_stg_d = RX_DATA;
        next_stg_e = 1'b0;
      end else if (next_out_v) begin
        next_stg_v = 1'b1;
        next_stg_d = RX_DATA;
        next_stg_e = RX_EOI;
      end else begin
        next_out_v = 1'b1;
        next_out_d = RX_DATA;
        next_end = RX_EOI;
      end
    end
  end

  // output formatter
  always @* begin
    next_st = st;
    next_pos = pos;
    next_cnt = cnt;
    next_tv = TX_VALID & !TX_READY;
    next_td = TX_DATA;
    case (st)
      `RMI_F_IDLE, `RMI_F_NEXT: begin
        if (rd_take) begin
          next_st = `RMI_F_RDG;
          next_pos = 4'h0;
        end else if (st == `RMI_F_IDLE & RESP_VALID & allow) begin
          next_st = `RMI_F_RESP;
          next_cnt = 7'h00;
        end
      end
      `RMI_F_RDG: begin
        if (slot) begin
          next_tv = 1'b1;
          next_td = rdg_char(pos, l_neg, l_dig, l_eneg, l_exp);
          next_pos = pos + 4'h1;
          if (pos == `RMI_POS_ELO & l_last)
            next_st = term;
          else if (pos == `RMI_POS_COMMA)
            next_st = `RMI_F_NEXT;
        end
      end
      `RMI_F_RESP: begin
        if (resp_take) begin
          if (cnt < `RMI_RESP_MAX) begin
            next_tv = 1'b1;
            next_td = RESP_DATA;
            next_cnt = cnt + 7'h01;
          end
          if (RESP_LAST)
            next_st = term;
        end
      end
      `RMI_F_CR: begin
        if (slot) begin
          next_tv = 1'b1;
          next_td = `RMI_CH_CR;
          next_st = `RMI_F_LF;
        end
      end
      `RMI_F_LF: begin
        if (slot) begin
          next_tv = 1'b1;
          next_td = `RMI_CH_LF;
          next_st = `RMI_F_IDLE;
        end
      end
      default: next_st = `RMI_F_IDLE;
    endcase
  end

  // settings: factory values at reset, then loaded from store
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ifsel <= 1'b0;
      par <= `RMI_PAR_EVEN;
      lang <= 1'b0;
      remote <= 1'b0;
      gaddr <= `RMI_ADDR_DEF;
      nv_wait <= 1'b1;
      NV_STORE <= 1'b0;
    end else if (CE) begin
      NV_STORE <= 1'b0;
      if (nv_wait) begin
        nv_wait <= 1'b0;
        ifsel <= NV_IFSEL;
        if (NV_PARITY != `RMI_PAR_BAD)
          par <= NV_PARITY;
        lang <= NV_LANG;
      end else if (ctl_wr) begin
        ifsel <= WDATA[`RMI_CTL_IF];
        if (WDATA[`RMI_CTL_PAR] != `RMI_PAR_BAD)
          par <= WDATA[`RMI_CTL_PAR];
        lang <= WDATA[`RMI_CTL_LANG];
        remote <= WDATA[`RMI_CTL_REM];
        NV_STORE <= 1'b1;
      end
      if (WR & ADDR == `RMI_OFS_ADDR)
        gaddr <= WDATA[4:0];
    end
  end

  // settings outputs, one interface enabled at a time
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      IF_GPIB <= 1'b1;
      IF_SERIAL <= 1'b0;
      TALK_ONLY <= 1'b0;
      LANG_ALT <= 1'b0;
      SER_DATA_BITS <= `RMI_BITS_7;
      SER_PAR_EN <= 1'b1;
      SER_PAR_ODD <= 1'b0;
      SER_STOP_BITS <= `RMI_STOP_BITS;
    end else if (CE) begin
      IF_GPIB <= !ifsel;
      IF_SERIAL <= ifsel;
      TALK_ONLY <= talk_only;
      LANG_ALT <= lang;
      SER_DATA_BITS <= (par == `RMI_PAR_NONE) ? `RMI_BITS_8 : `RMI_BITS_7;
      SER_PAR_EN <= (par != `RMI_PAR_NONE);
      SER_PAR_ODD <= (par == `RMI_PAR_ODD);
      SER_STOP_BITS <= `RMI_STOP_BITS;
    end
  end

  // receive path and message end; clear drops the held byte and the MSG_VALID and PATH_ROOT pulses
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      stg_v <= 1'b0;
      stg_d <= 8'h00;
      stg_e <= 1'b0;
      MSG_VALID <= 1'b0;
      MSG_DATA <= 8'h00;
      PATH_ROOT <= 1'b0;
    end else if (CE) begin
      if (clr) begin
        stg_v <= 1'b0;
        MSG_VALID <= 1'b0;
        PATH_ROOT <= 1'b0;
      end else begin
        stg_v <= next_stg_v;
        stg_d <= next_stg_d;
        stg_e <= next_stg_e;
        MSG_VALID <= next_out_v;
        MSG_DATA <= next_out_v ? next_out_d : MSG_DATA;
        PATH_ROOT <= next_end;
      end
    end
  end

  // clear actions; status and settings are not touched here
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      MEAS_ABORT <= 1'b0;
      TRIG_IDLE <= 1'b0;
      BUF_FLUSH <= 1'b0;
      DTR <= 1'b1;
    end else if (CE) begin
      MEAS_ABORT <= clr;
      TRIG_IDLE <= clr;
      BUF_FLUSH <= clr;
      DTR <= clr | (next_st == `RMI_F_IDLE);
    end
  end

  // formatter state and transmit holding register
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st <= `RMI_F_IDLE;
      pos <= 4'h0;
      cnt <= 7'h00;
      l_neg <= 1'b0;
      l_dig <= 36'h0;
      l_eneg <= 1'b0;
      l_exp <= 8'h00;
      l_last <= 1'b0;
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
      TX_FRAME <= 11'h7FF;
      RD_READY <= 1'b0;
      RESP_READY <= 1'b0;
    end else if (CE) begin
      if (clr) begin
        st <= `RMI_F_IDLE;
        TX_VALID <= 1'b0;
        RD_READY <= 1'b0;
        RESP_READY <= 1'b0;
      end else begin
        st <= next_st;
        pos <= next_pos;
        cnt <= next_cnt;
        TX_VALID <= next_tv;
        TX_DATA <= next_td;
        TX_FRAME <= frame(next_td, par);
        if (rd_take) begin
          l_neg <= RD_NEG;
          l_dig <= RD_DIG;
          l_eneg <= RD_EXP_NEG;
          l_exp <= RD_EXP;
          l_last <= RD_LAST;
        end
        RD_READY <= allow & (next_st == `RMI_F_IDLE | next_st == `RMI_F_NEXT);
        RESP_READY <= (next_st == `RMI_F_RESP) & !next_tv;
      end
    end
  end

  // register read, data one cycle after the strobe
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (CE) begin
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `RMI_OFS_CTRL: RDATA <= {3'b000, remote, lang, par, ifsel};
          `RMI_OFS_ADDR: RDATA <= {3'b000, gaddr};
          `RMI_OFS_STAT: RDATA <= {3'b000, nv_wait, stg_v, talk_only, DTR, st != `RMI_F_IDLE};
          default: RDATA <= 8'h00;
        endcase
      end
    end
  end

endmodule

/* File: rmi_chk.sv */
// assertion checker for the remote message front end
module rmi_chk (
  // clock and reset
  input logic SYS_CLK,
  input logic RST,
  input logic CE,
  // receive side
  input logic RX_VALID,
  input logic [7:0] RX_DATA,
  input logic RX_EOI,
  input logic RX_SERIAL,
  input logic GPIB_DCL,
  input logic MSG_VALID,
  input logic [7:0] MSG_DATA,
  input logic PATH_ROOT,
  // clear actions
  input logic MEAS_ABORT,
  input logic TRIG_IDLE,
  input logic BUF_FLUSH,
  input logic DTR,
  // readings and transmit
  input logic RD_VALID,
  input logic RD_NEG,
  input logic RD_READY,
  input logic TX_VALID,
  input logic [7:0] TX_DATA,
  input logic [10:0] TX_FRAME,
  // settings
  input logic IF_GPIB,
  input logic IF_SERIAL,
  input logic [3:0] SER_DATA_BITS,
  input logic SER_PAR_EN,
  input logic SER_PAR_ODD,
  input logic [1:0] SER_STOP_BITS
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // settings and frame shape
  one_if_a: assert property (IF_GPIB != IF_SERIAL)
    else $error("interface select not one-hot");
  bits_par_a: assert property (SER_DATA_BITS == (SER_PAR_EN ? 4'h7 : 4'h8))
    else $error("data bits disagree with parity");
  frame_stop_a: assert property (TX_VALID |-> TX_FRAME[10:9] == 2'h3 && !TX_FRAME[0] && SER_STOP_BITS == 2'h2)
    else $error("bad start or stop bits");
  frame_par_a: assert property (TX_VALID && SER_PAR_EN |-> TX_FRAME[8] == (^TX_FRAME[7:1] ^ SER_PAR_ODD))
    else $error("bad parity bit");
  // clear behaviour
  clr_set_a: assert property (MEAS_ABORT |-> TRIG_IDLE && BUF_FLUSH && DTR && !TX_VALID)
    else $error("incomplete clear");
  ctlc_clr_a: assert property (CE && RX_VALID && RX_SERIAL && IF_SERIAL && $past(IF_SERIAL) && RX_DATA == 8'h03
    |=> MEAS_ABORT)
    else $error("control-C did not clear");
  // message ends and reading sign
  eoi_end_a: assert property (CE && RX_VALID && RX_EOI && RX_SERIAL == IF_SERIAL && $stable(IF_SERIAL)
    && RX_DATA != 8'h03 && RX_DATA != 8'h0D && !GPIB_DCL |=> PATH_ROOT)
    else $error("EOI byte did not end message");
  no_lf_a: assert property (MSG_VALID |-> MSG_DATA != 8'h0A)
    else $error("newline forwarded");
  rdg_sign_a: assert property (CE && RD_VALID && RD_READY && !TX_VALID && !GPIB_DCL
    |-> ##2 TX_VALID && TX_DATA == ($past(RD_NEG, 2) ? 8'h2D : 8'h2B))
    else $error("reading sign wrong");
endmodule

bind rmi_top rmi_chk u_chk (.SYS_CLK, .RST, .CE, .RX_VALID, .RX_DATA, .RX_EOI, .RX_SERIAL, .GPIB_DCL,
  .MSG_VALID, .MSG_DATA, .PATH_ROOT, .MEAS_ABORT, .TRIG_IDLE, .BUF_FLUSH, .DTR, .RD_VALID, .RD_NEG,
  .RD_READY, .TX_VALID, .TX_DATA, .TX_FRAME, .IF_GPIB, .IF_SERIAL, .SER_DATA_BITS, .SER_PAR_EN,
  .SER_PAR_ODD, .SER_STOP_BITS);

/* File: rmi_host.sv */
// transmit sink standing in for the controller or serial host
module rmi_host (
  // clock
  input logic SYS_CLK,
  // transmit handshake
  input logic TX_VALID,
  input logic [7:0] TX_DATA,
  output logic TX_READY,
  // pacing
  input logic slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  initial TX_READY = 1'b0;
  // take a character per ready cycle, stall every other cycle when slow
  always @(posedge SYS_CLK) begin
    if (TX_VALID && TX_READY)
      q.push_back(TX_DATA);
    TX_READY <= slow ? ~TX_READY : 1'b1;
  end
endmodule

/* File: tb_top.sv */
// self-checking bench for the remote message front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_total++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
  logic SYS_CLK = 0, RST = 1, CE = 1, WR = 0, RD = 0, RX_VALID = 0, RX_EOI = 0, RX_SERIAL = 0, GPIB_DCL = 0;
  logic RD_VALID = 0, RD_NEG = 0, RD_EXP_NEG = 0, RD_LAST = 0, RESP_VALID = 0, RESP_LAST = 0, TALK_ADDR = 0;
  logic NV_IFSEL = 0, NV_LANG = 0, slow = 0;
  logic [1:0] NV_PARITY = 2'h1;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00, RX_DATA = 8'h00, RD_EXP = 8'h00, RESP_DATA = 8'h00, lmsg;
  logic [35:0] RD_DIG = 36'h000000000;
  wire [7:0] RDATA, MSG_DATA, TX_DATA;
  wire [10:0] TX_FRAME;
  wire [3:0] SER_DATA_BITS;
  wire [1:0] SER_STOP_BITS;
  wire MSG_VALID, PATH_ROOT, MEAS_ABORT, TRIG_IDLE, BUF_FLUSH, DTR, RD_READY, RESP_READY, TX_VALID, TX_READY;
  wire IF_GPIB, IF_SERIAL, TALK_ONLY, LANG_ALT, SER_PAR_EN, SER_PAR_ODD, NV_STORE;
  int err_total = 0, n_tests = 0, nmsg = 0, npath = 0, nclr = 0, nst = 0;

  rmi_top u_rmi_top (.SYS_CLK, .RST, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .RX_VALID, .RX_DATA, .RX_EOI,
    .RX_SERIAL, .GPIB_DCL, .MSG_VALID, .MSG_DATA, .PATH_ROOT, .MEAS_ABORT, .TRIG_IDLE, .BUF_FLUSH, .DTR,
    .RD_VALID, .RD_NEG, .RD_DIG, .RD_EXP_NEG, .RD_EXP, .RD_LAST, .RD_READY, .RESP_VALID, .RESP_DATA,
    .RESP_LAST, .RESP_READY, .TX_VALID, .TX_DATA, .TX_FRAME, .TX_READY, .TALK_ADDR, .IF_GPIB, .IF_SERIAL,
    .TALK_ONLY, .LANG_ALT, .SER_DATA_BITS, .SER_PAR_EN, .SER_PAR_ODD, .SER_STOP_BITS, .NV_IFSEL,
    .NV_PARITY, .NV_LANG, .NV_STORE);
  rmi_host u_host (.SYS_CLK, .TX_VALID, .TX_DATA, .TX_READY, .slow);

  // clock
  always #25 SYS_CLK = ~SYS_CLK;

  // count one-cycle output pulses
  always @(posedge SYS_CLK) begin
    if (MSG_VALID === 1'b1) begin
      nmsg++;
      lmsg = MSG_DATA;
    end
    if (PATH_ROOT === 1'b1)
      npath++;
    if ((MEAS_ABORT & TRIG_IDLE & BUF_FLUSH) === 1'b1)
      nclr++;
    if (NV_STORE === 1'b1)
      nst++;
  end

  // verdict and end of run
  task automatic test_done;
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic rst;
    RST <= 1;
    repeat (6) @(posedge SYS_CLK);
    RST <= 0;
    repeat (3) @(posedge SYS_CLK);
    #1;
  endtask

  task automatic settle;
    repeat (2) @(posedge SYS_CLK);
    #1;
  endtask

  task automatic wr(input [3:0] a, input [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1;
    @(posedge SYS_CLK);
    WR <= 0;
  endtask

  task automatic rd(input [3:0] a, input [7:0] e);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1;
    @(posedge SYS_CLK);
    RD <= 0;
    #1;
    `CHK("rdata", e, RDATA)
  endtask

  task automatic rx(input [7:0] d, input e, input s);
    @(posedge SYS_CLK);
    RX_VALID <= 1;
    RX_DATA <= d;
    RX_EOI <= e;
    RX_SERIAL <= s;
    @(posedge SYS_CLK);
    RX_VALID <= 0;
    repeat (3) @(posedge SYS_CLK);
  endtask

  task automatic rdg(input n, input [35:0] d, input en, input [7:0] e, input l);
    int i = 0;
    @(posedge SYS_CLK);
    RD_VALID <= 1;
    RD_NEG <= n;
    RD_DIG <= d;
    RD_EXP_NEG <= en;
    RD_EXP <= e;
    RD_LAST <= l;
    do begin
      @(posedge SYS_CLK);
      i++;
    end while (RD_READY !== 1'b1 && i < 500);
    RD_VALID <= 0;
  endtask

  task automatic txs(input string s);
    int i = 0;
    while (u_host.q.size() < s.len() && i < 3000) begin
      @(posedge SYS_CLK);
      i++;
    end
    repeat (8) @(posedge SYS_CLK);
    `CHK("tx count", s.len(), u_host.q.size())
    for (int j = 0; j < s.len(); j++)
      `CHK("tx char", s[j], u_host.q[j])
    u_host.q.delete();
  endtask

  // watchdog
  initial begin
    #500000;
    err_total++;
    test_done();
  end

  // test sequence
  initial begin
    string s = "";
    int k = 0;
    int i = 0;
    rst();
    `CHK("if bus", 1'b1, IF_GPIB)
    `CHK("bits", 4'h7, SER_DATA_BITS)
    `CHK("odd", 1'b0, SER_PAR_ODD)
    `CHK("lang", 1'b0, LANG_ALT)
    wr(4'h0, 8'h00);
    settle();
    `CHK("store", 1, nst)
    `CHK("bits", 4'h8, SER_DATA_BITS)
    `CHK("par en", 1'b0, SER_PAR_EN)
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h04);
    wr(4'h0, 8'h06);
    settle();
    `CHK("odd", 1'b1, SER_PAR_ODD)
    rd(4'h0, 8'h04);
    rd(4'hC, 8'h00);
    rd(4'h8, 8'h02);
    rx(8'h41, 0, 0);
    rx(8'h0A, 0, 0);
    `CHK("msgs", 1, nmsg)
    `CHK("byte", 8'h41, lmsg)
    `CHK("root", 1, npath)
    rx(8'h0D, 0, 0);
    rx(8'h0A, 0, 0);
    `CHK("msgs", 1, nmsg)
    `CHK("root", 2, npath)
    rx(8'h42, 1, 0);
    `CHK("byte", 8'h42, lmsg)
    `CHK("root", 3, npath)
    rx(8'h43, 0, 1);
    `CHK("msgs", 2, nmsg)
    @(posedge SYS_CLK);
    GPIB_DCL <= 1;
    @(posedge SYS_CLK);
    GPIB_DCL <= 0;
    settle();
    `CHK("clear", 1, nclr)
    `CHK("dtr", 1'b1, DTR)
    `CHK("odd", 1'b1, SER_PAR_ODD)
    // addressed to talk at the default address, never 31
    TALK_ADDR <= 1;
    @(posedge SYS_CLK);
    RESP_VALID <= 1;
    RESP_DATA <= 8'h61;
    while (k < 80 && i < 2000) begin
      @(posedge SYS_CLK);
      i++;
      if (RESP_READY === 1'b1) begin
        k++;
        RESP_LAST <= (k == 79);
      end
    end
    RESP_VALID <= 0;
    TALK_ADDR <= 0;
    for (int j = 0; j < 79; j++)
      s = {s, "a"};
    txs({s, "\n"});
    wr(4'h4, 8'h1F);
    settle();
    `CHK("talk only", 1'b1, TALK_ONLY)
    rdg(0, 36'h123456789, 1, 8'h05, 1);
    txs("+1.23456789E-05\n");
    wr(4'h0, 8'h05);
    settle();
    `CHK("if ser", 1'b1, IF_SERIAL)
    `CHK("if bus", 1'b0, IF_GPIB)
    slow <= 1;
    rdg(1, 36'h987654321, 0, 8'h12, 0);
    rdg(0, 36'h123456789, 1, 8'h05, 1);
    txs("-9.87654321E+12,+1.23456789E-05\r\n");
    wr(4'h0, 8'h25);
    settle();
    `CHK("clear", 2, nclr)
    `CHK("odd", 1'b1, SER_PAR_ODD)
    rx(8'h03, 0, 1);
    `CHK("clear", 3, nclr)
    `CHK("msgs", 2, nmsg)
    @(posedge SYS_CLK);
    NV_IFSEL <= 1;
    NV_PARITY <= 2'h0;
    NV_LANG <= 1;
    rst();
    `CHK("if ser", 1'b1, IF_SERIAL)
    `CHK("bits", 4'h8, SER_DATA_BITS)
    `CHK("lang", 1'b1, LANG_ALT)
    test_done();
  end
endmodule
